// >>> design/channel_compare.sv
`timescale 1ns/1ps

module channel_compare #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic [COUNT_WIDTH-1:0] count_in, // Fresh measurement.
  input wire logic [COUNT_WIDTH-1:0] baseline_in, // Untouched reference.
  input wire logic [7:0] threshold_in, // Touch threshold.
  output logic touched_out // Delta exceeds the threshold.
);

  logic [COUNT_WIDTH:0] delta;

  // A measurement below the baseline gives a negative delta and is never a touch.
  assign delta = {1'b0, count_in} - {1'b0, baseline_in};
  assign touched_out = !delta[COUNT_WIDTH] && (delta > (COUNT_WIDTH + 1)'(threshold_in));

endmodule

// >>> design/cycle_timer.sv
`timescale 1ns/1ps
`include "touch_scan_params.svh"

module cycle_timer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock_in, // System clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic start_in, // Restart the period.
  input wire logic [7:0] period_ms_in, // Period length in milliseconds.
  output logic expired_out // Period has run out.
);

  logic [31:0] divider;
  logic [7:0] ms_count;
  logic tick;

  assign tick = (divider == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      divider <= 32'h0;
    end else if (start_in || tick) begin
      divider <= 32'h0;
    end else begin
      divider <= divider + 32'h1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ms_count <= 8'h0;
      expired_out <= 1'b0;
    end else if (start_in) begin
      ms_count <= 8'h0;
      expired_out <= 1'b0;
    end else if (tick && !expired_out) begin
      ms_count <= ms_count + 8'h1;
      expired_out <= (ms_count + 8'h1 >= period_ms_in);
    end
  end

endmodule

// >>> design/touch_scan_params.svh
`ifndef TOUCH_SCAN_PARAMS_SVH
`define TOUCH_SCAN_PARAMS_SVH

// Register offsets.
`define ADDR_CONTROL 8'h00
`define ADDR_ACTIVE_ENABLE 8'h01
`define ADDR_ACTIVE_CONFIG 8'h02
`define ADDR_STANDBY_ENABLE 8'h03
`define ADDR_STANDBY_CONFIG 8'h04
`define ADDR_STANDBY_THRESHOLD 8'h05
`define ADDR_TOUCH_STATUS 8'h06
`define ADDR_STATE 8'h07
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_CLEAR 8'h09
`define ADDR_IRQ_ENABLE 8'h0A
`define ADDR_CAL_PENDING 8'h0B
`define ADDR_THRESHOLD_BASE 8'h10

// Control register fields.
`define CTRL_STANDBY_BIT 0
`define CTRL_MIXED_BIT 1
`define CTRL_DEEP_BIT 2

// Configuration register fields, shared by the active and standby layouts.
`define CFG_PERIOD_LSB 0
`define CFG_AMP_LSB 2
`define CFG_SENS_LSB 4

// Interrupt status bits.
`define IRQ_TOUCH_BIT 0
`define IRQ_OVERRUN_BIT 1
`define IRQ_STATE_BIT 2

// Reset values.
`define RST_CONTROL 8'h00
`define RST_ACTIVE_ENABLE 8'hFF
`define RST_STANDBY_ENABLE 8'h00
`define RST_CONFIG 8'h21
`define RST_THRESHOLD 8'h40
`define RST_IRQ_ENABLE 8'h00
`define RST_CAL_PENDING 8'hFF

// Timing.
`define CLOCK_KHZ 40000
`define TICK_US 1000
`define TICK_CYCLES ((`CLOCK_KHZ * `TICK_US) / 1000)
`define PERIOD_UNIT_MS 35

`endif

// >>> design/touch_scan_pkg.sv
package touch_scan_pkg;

  typedef enum logic [1:0] {
    POWER_ACTIVE = 2'h0,
    POWER_STANDBY = 2'h1,
    POWER_COMBO = 2'h3,
    POWER_DEEP = 2'h2
  } power_state_e;

  typedef enum logic [1:0] {
    SCAN_SEEK = 2'h0,
    SCAN_MEASURE = 2'h1,
    SCAN_IDLE = 2'h3,
    SCAN_SLEEP = 2'h2
  } scan_state_e;

endpackage

// >>> design/touch_scan_power_state_control.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "touch_scan_params.svh"

module touch_scan_power_state_control
  import touch_scan_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int COUNT_WIDTH = 16,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clock_in, // 40 MHz system clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic [7:0] addr_in, // Register address.
  input wire logic [7:0] wdata_in, // Register write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  output logic [7:0] rdata_out, // Read data, one cycle after the strobe.
  input wire logic bus_active_in, // Serial bus traffic addressed to us.
  output logic meas_req_out, // Pulse: start a measurement.
  output logic [2:0] meas_channel_out, // Channel to measure.
  output logic [1:0] meas_amp_out, // Amplification for the measurement.
  output logic [2:0] meas_sens_out, // Sensitivity for the measurement.
  output logic meas_standby_cfg_out, // Measurement uses standby settings.
  input wire logic meas_done_in, // Pulse: measurement finished.
  input wire logic [COUNT_WIDTH-1:0] meas_count_in, // Measured count.
  output logic [CHANNELS-1:0] touch_out, // Per-input touch status.
  output logic [1:0] power_state_out, // Current power state.
  output logic low_power_out, // Idle for the rest of the cycle.
  output logic awake_out, // Digital core running.
  output logic irq_out // Level interrupt.
);

  function automatic logic [3:0] next_enabled(input logic [CHANNELS-1:0] mask, input logic [3:0] from);
    logic [3:0] found;
    found = 4'(CHANNELS);
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        found = 4'(i);
      end
    end
    return found;
  endfunction

  function automatic logic [7:0] field_period(input logic [1:0] sel);
    return 8'((32'(sel) + 32'h1) * `PERIOD_UNIT_MS);
  endfunction

  logic [7:0] control;
  logic [CHANNELS-1:0] active_enable;
  logic [7:0] active_config;
  logic [CHANNELS-1:0] standby_enable;
  logic [7:0] standby_config;
  logic [7:0] standby_threshold;
  logic [7:0] active_threshold [CHANNELS];
  logic [7:0] irq_status;
  logic [7:0] irq_enable;
  logic [CHANNELS-1:0] cal_pending;
  logic [COUNT_WIDTH-1:0] baseline [CHANNELS];
  logic [CHANNELS-1:0] prev_monitored;
  power_state_e power;
  power_state_e next_power;
  scan_state_e scan;
  logic [3:0] channel;
  logic [3:0] seek;
  logic [CHANNELS-1:0] monitored;
  logic [CHANNELS-1:0] standby_set;
  logic state_change;
  logic restart;
  logic timer_expired;
  logic [7:0] period_ms;
  logic [7:0] threshold_now;
  logic touched;
  logic touch_event;
  logic overrun_event;
  logic measure_done;

  always_comb begin
    if (control[`CTRL_DEEP_BIT]) begin
      next_power = POWER_DEEP;
    end else if (control[`CTRL_MIXED_BIT]) begin
      next_power = POWER_COMBO;
    end else if (control[`CTRL_STANDBY_BIT]) begin
      next_power = POWER_STANDBY;
    end else begin
      next_power = POWER_ACTIVE;
    end
  end

  always_comb begin
    case (power)
      POWER_ACTIVE: begin
        monitored = active_enable;
        standby_set = '0;
      end
      POWER_STANDBY: begin
        monitored = standby_enable;
        standby_set = standby_enable;
      end
      POWER_COMBO: begin
        monitored = active_enable | standby_enable;
        standby_set = standby_enable & ~active_enable;
      end
      default: begin
        monitored = '0;
        standby_set = '0;
      end
    endcase
  end

  assign state_change = (next_power != power);
  assign seek = next_enabled(monitored, channel);
  assign period_ms = (power == POWER_ACTIVE) ? field_period(active_config[`CFG_PERIOD_LSB +: 2])
                                             : field_period(standby_config[`CFG_PERIOD_LSB +: 2]);
  assign threshold_now = standby_set[channel[2:0]] ? standby_threshold
                                                   : active_threshold[channel[2:0]];
  assign measure_done = (scan == SCAN_MEASURE) && meas_done_in;
  assign restart = (scan == SCAN_SEEK && seek == 4'(CHANNELS) && timer_expired)
                || (scan == SCAN_IDLE && timer_expired)
                || (scan == SCAN_SLEEP && next_power != POWER_DEEP)
                || (state_change && next_power != POWER_DEEP);
  assign touch_event = measure_done && !cal_pending[channel[2:0]] && touched && !touch_out[channel[2:0]];
  assign overrun_event = (scan == SCAN_SEEK) && (seek == 4'(CHANNELS)) && timer_expired && !state_change;

  cycle_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) period_timer (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .start_in(restart),
    .period_ms_in(period_ms),
    .expired_out(timer_expired)
  );

  channel_compare #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) compare (
    .count_in(meas_count_in),
    .baseline_in(baseline[channel[2:0]]),
    .threshold_in(threshold_now),
    .touched_out(touched)
  );

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control <= `RST_CONTROL;
      active_enable <= `RST_ACTIVE_ENABLE;
      active_config <= `RST_CONFIG;
      standby_enable <= `RST_STANDBY_ENABLE;
      standby_config <= `RST_CONFIG;
      standby_threshold <= `RST_THRESHOLD;
      irq_enable <= `RST_IRQ_ENABLE;
      for (int i = 0; i < CHANNELS; i++) begin
        active_threshold[i] <= `RST_THRESHOLD;
      end
    end else if (wr_in) begin
      case (addr_in)
        `ADDR_CONTROL: control <= wdata_in & 8'h07;
        `ADDR_ACTIVE_ENABLE: active_enable <= wdata_in[CHANNELS-1:0];
        `ADDR_ACTIVE_CONFIG: active_config <= wdata_in & 8'h7F;
        `ADDR_STANDBY_ENABLE: standby_enable <= wdata_in[CHANNELS-1:0];
        `ADDR_STANDBY_CONFIG: standby_config <= wdata_in & 8'h7F;
        `ADDR_STANDBY_THRESHOLD: standby_threshold <= wdata_in;
        `ADDR_IRQ_ENABLE: irq_enable <= wdata_in & 8'h07;
        default: begin
          if (addr_in[7:3] == `ADDR_THRESHOLD_BASE >> 3) begin
            active_threshold[addr_in[2:0]] <= wdata_in;
          end
        end
      endcase
    end
  end

  // Reads of unmapped or write-only addresses return zero.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_CONTROL: rdata_out <= control;
        `ADDR_ACTIVE_ENABLE: rdata_out <= active_enable;
        `ADDR_ACTIVE_CONFIG: rdata_out <= active_config;
        `ADDR_STANDBY_ENABLE: rdata_out <= standby_enable;
        `ADDR_STANDBY_CONFIG: rdata_out <= standby_config;
        `ADDR_STANDBY_THRESHOLD: rdata_out <= standby_threshold;
        `ADDR_TOUCH_STATUS: rdata_out <= touch_out;
        `ADDR_STATE: rdata_out <= {4'h0, awake_out, low_power_out, power};
        `ADDR_IRQ_STATUS: rdata_out <= irq_status;
        `ADDR_IRQ_ENABLE: rdata_out <= irq_enable;
        `ADDR_CAL_PENDING: rdata_out <= cal_pending;
        default: begin
          if (addr_in[7:3] == `ADDR_THRESHOLD_BASE >> 3) begin
            rdata_out <= active_threshold[addr_in[2:0]];
          end else begin
            rdata_out <= 8'h00;
          end
        end
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power <= POWER_ACTIVE;
      prev_monitored <= '0;
    end else begin
      power <= next_power;
      prev_monitored <= monitored;
    end
  end

  // Deep sleep keeps the core up only while the bus is talking to us; the bit itself stays set.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      awake_out <= 1'b1;
    end else begin
      awake_out <= (next_power != POWER_DEEP) || bus_active_in;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan <= SCAN_SEEK;
      channel <= 4'h0;
      meas_req_out <= 1'b0;
      meas_channel_out <= 3'h0;
      meas_amp_out <= 2'h0;
      meas_sens_out <= 3'h0;
      meas_standby_cfg_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      meas_req_out <= 1'b0;
      if (next_power == POWER_DEEP) begin
        scan <= SCAN_SLEEP;
        channel <= 4'h0;
        low_power_out <= 1'b1;
      end else if (restart) begin
        scan <= SCAN_SEEK;
        channel <= 4'h0;
        low_power_out <= 1'b0;
      end else begin
        case (scan)
          SCAN_SEEK: begin
            if (seek == 4'(CHANNELS)) begin
              scan <= SCAN_IDLE;
              low_power_out <= 1'b1;
            end else begin
              scan <= SCAN_MEASURE;
              channel <= seek;
              meas_req_out <= 1'b1;
              meas_channel_out <= seek[2:0];
              meas_standby_cfg_out <= standby_set[seek[2:0]];
              if (standby_set[seek[2:0]]) begin
                meas_sens_out <= standby_config[`CFG_SENS_LSB +: 3];
                meas_amp_out <= (power == POWER_COMBO) ? standby_config[`CFG_AMP_LSB +: 2]
                                                       : active_config[`CFG_AMP_LSB +: 2];
              end else begin
                meas_sens_out <= active_config[`CFG_SENS_LSB +: 3];
                meas_amp_out <= active_config[`CFG_AMP_LSB +: 2];
              end
            end
          end
          SCAN_MEASURE: begin
            if (meas_done_in) begin
              scan <= SCAN_SEEK;
              channel <= channel + 4'h1;
            end
          end
          SCAN_IDLE: begin
            low_power_out <= 1'b1;
          end
          default: begin
            scan <= SCAN_SEEK;
            low_power_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // A power state change clears the touch of every input; an input disabled by an enable write keeps its touch.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      touch_out <= '0;
    end else if (state_change) begin
      touch_out <= '0;
    end else if (measure_done && !cal_pending[channel[2:0]]) begin
      touch_out[channel[2:0]] <= touched;
    end
  end

  // The first measurement of a calibrating input becomes its baseline and is never a touch.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_pending <= `RST_CAL_PENDING;
      for (int i = 0; i < CHANNELS; i++) begin
        baseline[i] <= '0;
      end
    end else begin
      if (measure_done && cal_pending[channel[2:0]]) begin
        baseline[channel[2:0]] <= meas_count_in;
      end
      cal_pending <= (cal_pending & ~(CHANNELS'(measure_done) << channel[2:0]))
                   | (monitored & ~prev_monitored);
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= (irq_status & ~(wr_in && addr_in == `ADDR_IRQ_CLEAR ? wdata_in : 8'h00))
                  | ({7'h0, touch_event} << `IRQ_TOUCH_BIT)
                  | ({7'h0, overrun_event} << `IRQ_OVERRUN_BIT)
                  | ({7'h0, state_change} << `IRQ_STATE_BIT);
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_enable);
    end
  end

  touch_irq_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    touch_event |=> irq_status[`IRQ_TOUCH_BIT])
    else $error("New touch did not set its status bit.");

  assign power_state_out = power;

  sleep_no_meas_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (power == POWER_DEEP) |-> !meas_req_out)
    else $error("Measurement requested in deep sleep.");

  state_clears_touch_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    state_change |=> (touch_out == '0))
    else $error("Touch status survived a power state change.");

  active_mask_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (scan == SCAN_SEEK && power == POWER_ACTIVE && seek != 4'(CHANNELS) && !state_change)
    |=> meas_req_out && $past(active_enable[seek[2:0]]))
    else $error("Active scan measured a disabled input.");

  standby_cfg_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (meas_req_out && power == POWER_STANDBY) |-> meas_standby_cfg_out)
    else $error("Standby input measured without standby settings.");

  combo_both_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (meas_req_out && power == POWER_COMBO && active_enable[meas_channel_out]) |-> !meas_standby_cfg_out)
    else $error("Input in both sets did not use active settings.");

  ascending_order_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (measure_done && !restart && next_power != POWER_DEEP)
    |=> (channel == $past(channel) + 4'h1))
    else $error("Channel did not advance after a measurement.");

  idle_until_period_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (scan == SCAN_IDLE && !timer_expired && !state_change && next_power != POWER_DEEP) |=> scan == SCAN_IDLE)
    else $error("Idle left before the period ended.");

  overrun_restart_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    overrun_event |=> (scan == SCAN_SEEK && channel == 4'h0 && !low_power_out))
    else $error("Late cycle did not restart at once without idling.");

  calibrate_new_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (monitored & ~prev_monitored) != '0 |=> (cal_pending & $past(monitored & ~prev_monitored)) != '0)
    else $error("Newly enabled input not marked for calibration.");

  precedence_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    control[`CTRL_DEEP_BIT] |=> power == POWER_DEEP)
    else $error("Deep sleep did not take precedence.");

endmodule

// >>> verif/meas_frontend_model.sv
`timescale 1ns/1ps

module meas_frontend_model (
  input wire logic clock_in, // System clock.
  input wire logic req_in, // Measurement request pulse.
  input wire logic [2:0] ch_in, // Channel to measure.
  input wire logic [7:0] delay_in, // Answer latency in cycles, at least 1.
  input wire logic [7:0] touch_mask_in, // Pads that are being touched.
  input wire logic [15:0] delta_in, // Count rise on a touched pad.
  output logic done_out, // Measurement finished pulse.
  output logic [15:0] count_out // Measured count.
);
  logic [7:0] left = 8'h00;
  logic [2:0] ch = 3'h0;

  initial begin
    done_out = 1'b0;
    count_out = 16'h0000;
  end

  // The count bus toggles outside the done pulse so a stale value is never mistaken for data.
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    count_out <= ~count_out;
    if (req_in) begin
      ch <= ch_in;
      left <= delay_in;
    end else if (left == 8'h01) begin
      done_out <= 1'b1;
      count_out <= 16'h1000 + (touch_mask_in[ch] ? delta_in : 16'h0000);
      left <= 8'h00;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule

// >>> verif/touch_scan_power_state_control_tb_top.sv
`timescale 1ns/1ps
`include "touch_scan_params.svh"

module touch_scan_power_state_control_tb_top;
  import touch_scan_pkg::*;
  logic clock_in, arst_n_in, wr, rd, bus_act, done, req, sbc, lowp, awake, irq;
  logic [7:0] addr, wdata, rdata, touch, delay, tmask, v;
  logic [2:0] ch, sens;
  logic [1:0] amp, pstate;
  logic [15:0] count, delta;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  touch_scan_power_state_control #(.TICK_CYCLES(4)) i_dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bus_active_in(bus_act),
    .meas_req_out(req), .meas_channel_out(ch), .meas_amp_out(amp), .meas_sens_out(sens),
    .meas_standby_cfg_out(sbc), .meas_done_in(done), .meas_count_in(count),
    .touch_out(touch), .power_state_out(pstate), .low_power_out(lowp),
    .awake_out(awake), .irq_out(irq));

  meas_frontend_model i_fe (.clock_in(clock_in), .req_in(req), .ch_in(ch), .delay_in(delay),
    .touch_mask_in(tmask), .delta_in(delta), .done_out(done), .count_out(count));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) cyc <= cyc + 1;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string n);
    rd_reg(a);
    chk(n, e, v);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic next_req(output logic [2:0] c);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock_in);
      #1;
      if (req === 1'b1) break;
    end
    if (i == 2000) begin
      error_cnt++;
      $display("Error request expected 1 seen 0");
      report_and_stop();
    end
    c = ch;
  endtask

  function automatic logic [2:0] nxt(input logic [2:0] p, input logic [7:0] m);
    logic [2:0] c;
    c = p;
    repeat (8) begin
      c = c + 3'h1;
      if (m[c]) return c;
    end
    return p;
  endfunction

  task automatic scan_check(input logic [7:0] m, sbm, input logic [1:0] amp_a, amp_s,
      input logic [2:0] sens_a, sens_s);
    logic [2:0] c, p;
    next_req(p);
    repeat (9) begin
      next_req(c);
      chk("order", nxt(p, m), c);
      chk("cfg", sbm[c], sbc);
      chk("amp", sbm[c] ? amp_s : amp_a, amp);
      chk("sens", sbm[c] ? sens_s : sens_a, sens);
      p = c;
    end
  endtask

  task automatic watch(input int n, output int reqs, output logic lp);
    reqs = 0;
    lp = 1'b0;
    repeat (n) begin
      @(posedge clock_in);
      #1;
      if (req === 1'b1) reqs++;
      if (lowp !== 1'b0) lp = 1'b1;
    end
  endtask

  task automatic test_reset();
    chk_reg(`ADDR_CONTROL, `RST_CONTROL, "control");
    chk_reg(`ADDR_ACTIVE_ENABLE, `RST_ACTIVE_ENABLE, "act en");
    chk_reg(`ADDR_ACTIVE_CONFIG, `RST_CONFIG, "act cfg");
    chk_reg(`ADDR_STANDBY_ENABLE, `RST_STANDBY_ENABLE, "sb en");
    chk_reg(`ADDR_STANDBY_CONFIG, `RST_CONFIG, "sb cfg");
    chk_reg(`ADDR_STANDBY_THRESHOLD, `RST_THRESHOLD, "sb thr");
    chk_reg(`ADDR_IRQ_ENABLE, `RST_IRQ_ENABLE, "irq en");
    chk_reg(`ADDR_IRQ_CLEAR, 8'h00, "irq clr");
    chk_reg(8'h30, 8'h00, "unmapped");
    wr_reg(`ADDR_TOUCH_STATUS, 8'hFF);
    chk_reg(`ADDR_TOUCH_STATUS, 8'h00, "touch ro");
    for (int i = 0; i < 8; i++) chk_reg(`ADDR_THRESHOLD_BASE + 8'(i), `RST_THRESHOLD, "thr");
    chk("power", 8'(POWER_ACTIVE), 8'(pstate));
    $display("reset test done");
  endtask

  task automatic test_active();
    wr_reg(`ADDR_ACTIVE_CONFIG, 8'h34);
    wr_reg(`ADDR_ACTIVE_ENABLE, 8'hA5);
    wait_n(300);
    scan_check(8'hA5, 8'h00, 2'h1, 2'h1, 3'h3, 3'h3);
    $display("active test done");
  endtask

  task automatic test_touch();
    tmask = 8'h04;
    delta = 16'h0040;
    wait_n(300);
    chk("touch at thr", 8'h00, touch);
    delta = 16'h0041;
    wr_reg(`ADDR_THRESHOLD_BASE + 8'h05, 8'h80);
    tmask = 8'h24;
    wait_n(300);
    chk("touch over thr", 8'h04, touch);
    rd_reg(`ADDR_IRQ_STATUS);
    chk("irq touch", 8'h01, {7'h00, v[0]});
    wr_reg(`ADDR_IRQ_ENABLE, 8'h01);
    wait_n(3);
    chk("irq on", 8'h01, {7'h00, irq});
    wr_reg(`ADDR_IRQ_CLEAR, 8'h07);
    wait_n(3);
    chk("irq off", 8'h00, {7'h00, irq});
    tmask = 8'h02;
    delta = 16'h0080;
    wr_reg(`ADDR_ACTIVE_ENABLE, 8'hA7);
    wait_n(300);
    chk("new input", 8'h00, touch);
    $display("touch test done");
  endtask

  task automatic test_standby();
    tmask = 8'h04;
    delta = 16'h0041;
    wait_n(300);
    chk("pre touch", 8'h04, touch);
    wr_reg(`ADDR_STANDBY_THRESHOLD, 8'h10);
    wr_reg(`ADDR_STANDBY_CONFIG, 8'h58);
    wr_reg(`ADDR_STANDBY_ENABLE, 8'h0C);
    wr_reg(`ADDR_CONTROL, 8'h01);
    wait_n(2);
    chk("touch cleared", 8'h00, touch);
    chk("power", 8'(POWER_STANDBY), 8'(pstate));
    tmask = 8'h00;
    wait_n(300);
    wr_reg(`ADDR_IRQ_CLEAR, 8'h07);
    tmask = 8'h08;
    delta = 16'h0020;
    wait_n(300);
    chk("sb touch", 8'h08, touch);
    chk("sb irq", 8'h01, {7'h00, irq});
    scan_check(8'h0C, 8'h0C, 2'h1, 2'h1, 3'h3, 3'h5);
    chk_reg(`ADDR_CONTROL, 8'h01, "sb bus");
    wr_reg(`ADDR_CONTROL, 8'h00);
    wait_n(3);
    chk("power", 8'(POWER_ACTIVE), 8'(pstate));
    chk("touch cleared", 8'h00, touch);
    tmask = 8'h00;
    scan_check(8'hA7, 8'h00, 2'h1, 2'h1, 3'h3, 3'h3);
    $display("standby test done");
  endtask

  task automatic test_combo();
    logic [2:0] c;
    int t0;
    wr_reg(`ADDR_ACTIVE_ENABLE, 8'h03);
    wr_reg(`ADDR_STANDBY_ENABLE, 8'h06);
    wr_reg(`ADDR_ACTIVE_CONFIG, 8'h37);
    wr_reg(`ADDR_CONTROL, 8'h02);
    wait_n(3);
    chk("power", 8'(POWER_COMBO), 8'(pstate));
    scan_check(8'h07, 8'h04, 2'h1, 2'h2, 3'h3, 3'h5);
    c = 3'h1;
    for (int i = 0; i < 8 && c != 3'h0; i++) next_req(c);
    t0 = cyc;
    c = 3'h1;
    for (int i = 0; i < 8 && c != 3'h0; i++) next_req(c);
    chk("combo period", 8'h01, {7'h00, (cyc - t0 >= 140 && cyc - t0 <= 146)});
    wr_reg(`ADDR_CONTROL, 8'h00);
    wait_n(3);
    chk("power", 8'(POWER_ACTIVE), 8'(pstate));
    wr_reg(`ADDR_ACTIVE_CONFIG, 8'h34);
    $display("combo test done");
  endtask

  task automatic test_deep();
    int r;
    logic lp;
    logic [2:0] c;
    wr_reg(`ADDR_CONTROL, 8'h07);
    wait_n(3);
    chk("power", 8'(POWER_DEEP), 8'(pstate));
    watch(300, r, lp);
    chk("deep scans", 8'h00, 8'(r));
    chk("deep low", 8'h01, {7'h00, lowp});
    chk("deep awake", 8'h00, {7'h00, awake});
    @(posedge clock_in);
    bus_act <= 1'b1;
    wait_n(3);
    chk("woken", 8'h01, {7'h00, awake});
    chk_reg(`ADDR_CONTROL, 8'h07, "deep bus");
    watch(300, r, lp);
    chk("woken scans", 8'h00, 8'(r));
    @(posedge clock_in);
    bus_act <= 1'b0;
    wait_n(3);
    chk("back asleep", 8'h00, {7'h00, awake});
    wr_reg(`ADDR_CONTROL, 8'h00);
    // The first request after waking comes two edges after the write, so look before it passes.
    wait_n(1);
    chk("power", 8'(POWER_ACTIVE), 8'(pstate));
    next_req(c);
    chk("restart ch", 8'h00, 8'(c));
    $display("deep test done");
  endtask

  task automatic test_stretch();
    int r;
    logic lp;
    wr_reg(`ADDR_ACTIVE_ENABLE, 8'hFF);
    delay = 8'd40;
    wait_n(400);
    wr_reg(`ADDR_IRQ_CLEAR, 8'h07);
    watch(500, r, lp);
    chk("late low", 8'h00, {7'h00, lp});
    chk("late scan", 8'h01, {7'h00, r >= 8});
    rd_reg(`ADDR_IRQ_STATUS);
    chk("stretch irq", 8'h01, {7'h00, v[1]});
    delay = 8'd2;
    wait_n(400);
    watch(300, r, lp);
    chk("early low", 8'h01, {7'h00, lp});
    chk("early scan", 8'h01, {7'h00, r >= 8});
    $display("stretch test done");
  endtask

  initial begin
    arst_n_in = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bus_act = 1'b0;
    delay = 8'd2;
    tmask = 8'h00;
    delta = 16'h0000;
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    test_reset();
    test_active();
    test_touch();
    test_standby();
    test_combo();
    test_deep();
    test_stretch();
    report_and_stop();
  end
endmodule
